// ### hw/brwag_top.v
`timescale 1ns/10ps
// How it works
// - only X-side writes get bit reversal; reads and Y side stay ordinary
// - bits 11-8 pick W0..W14 as reversal pointer; 1111 switches it off
// - reversal works only while enable bit 15 of reversal control is set
// - reversal control bits 14:0 hold the modifier setting buffer size
// - reversal only for indirect pre- or post-increment modes
// - reversal only for word accesses; byte accesses use normal arithmetic
// - pointer in both circular and reversal: writes get reversal
// - pointer in both circular and reversal: reads get circular checking
// - valid modifiers are single powers of two 0x0001 to 0x4000
// - pointer plus modifier by reverse-carry addition, carries run downward
// - modifier shifted left one bit to address words
// - only bits inside the pivot change; bits above stay unchanged
// - pointer bit 0 is never altered by reversal
// - mode control bit 15 enables X read and write circular addressing
// - mode control bit 14 enables Y circular addressing
// - bits 3-0 pick X circular pointer W0..W14; 1111 disables
// - bits 7-4 pick Y circular pointer W10 or W11; 1111 disables
// - mode control bits 13-12 read back as zero
// - Y circular active only with enable set and select not 15
`include "brwag_consts.vh"

module brwag_top #(
    parameter AW = 4,
    parameter PW = 16
) (
    input  wire          clk_i,
    input  wire          resetn_i,
    input  wire          ce_i,
    // register bus
    input  wire [AW-1:0] s_axi_awaddr_i,
    input  wire [2:0]    s_axi_awprot_i,
    input  wire          s_axi_awvalid_i,
    output wire          s_axi_awready_o,
    input  wire [31:0]   s_axi_wdata_i,
    input  wire [3:0]    s_axi_wstrb_i,
    input  wire          s_axi_wvalid_i,
    output wire          s_axi_wready_o,
    output wire [1:0]    s_axi_bresp_o,
    output wire          s_axi_bvalid_o,
    input  wire          s_axi_bready_i,
    input  wire [AW-1:0] s_axi_araddr_i,
    input  wire [2:0]    s_axi_arprot_i,
    input  wire          s_axi_arvalid_i,
    output wire          s_axi_arready_o,
    output wire [31:0]   s_axi_rdata_o,
    output wire [1:0]    s_axi_rresp_o,
    output wire          s_axi_rvalid_o,
    input  wire          s_axi_rready_i,
    // address request from the pipeline
    input  wire          req_valid_i,
    input  wire          req_write_i,
    input  wire          req_yside_i,
    input  wire          req_byte_i,
    input  wire [2:0]    req_mode_i,
    input  wire [3:0]    req_ptr_sel_i,
    input  wire [PW-1:0] req_ptr_i,
    input  wire [PW-1:0] req_offset_i,
    // result, one cycle later
    output wire          ea_valid_o,
    output wire [PW-1:0] ea_o,
    output wire [PW-1:0] ptr_next_o,
    output wire          ptr_update_o,
    output wire          reversal_applied_o,
    output wire          circular_check_o
);
    // control registers
    reg  [15:0]   addr_mode_control_reg;
    reg  [15:0]   reversal_control_reg;

    // bus state
    reg           bvalid_reg;
    reg  [1:0]    bresp_reg;
    reg           rvalid_reg;
    reg  [31:0]   rdata_reg;
    reg  [1:0]    rresp_reg;

    // result state
    reg           ea_valid_reg;
    reg  [PW-1:0] ea_reg;
    reg  [PW-1:0] ptr_next_reg;
    reg           ptr_update_reg;
    reg           rev_applied_reg;
    reg           circ_check_reg;
    reg  [15:0]   rev_count_reg;
    reg  [15:0]   circ_count_reg;

    // field views
    wire          x_circular_enable;
    wire          y_circular_enable;
    wire [3:0]    reversal_pointer_select;
    wire [3:0]    y_circular_pointer_select;
    wire [3:0]    x_circular_pointer_select;
    wire          reversal_enable;
    wire [14:0]   reversal_modifier;

    assign x_circular_enable         = addr_mode_control_reg[`BRWAG_AMC_XCIR_EN];
    assign y_circular_enable         = addr_mode_control_reg[`BRWAG_AMC_YCIR_EN];
    assign reversal_pointer_select   = addr_mode_control_reg[`BRWAG_AMC_RSEL_HI:`BRWAG_AMC_RSEL_LO];
    assign y_circular_pointer_select = addr_mode_control_reg[`BRWAG_AMC_YSEL_HI:`BRWAG_AMC_YSEL_LO];
    assign x_circular_pointer_select = addr_mode_control_reg[`BRWAG_AMC_XSEL_HI:`BRWAG_AMC_XSEL_LO];
    assign reversal_enable           = reversal_control_reg[`BRWAG_RVC_EN];
    assign reversal_modifier         = reversal_control_reg[`BRWAG_RVC_MOD_HI:`BRWAG_RVC_MOD_LO];

    // ---------------- register bus ----------------
    wire          wr_fire;
    wire          rd_fire;
    wire [AW-1:0] wr_ofs;
    wire [AW-1:0] rd_ofs;

    // both channels taken together; holding one alone would need a skid
    assign s_axi_awready_o = ce_i & s_axi_awvalid_i & s_axi_wvalid_i & ~bvalid_reg;
    assign s_axi_wready_o  = s_axi_awready_o;
    assign wr_fire         = s_axi_awready_o;
    assign s_axi_arready_o = ce_i & ~rvalid_reg;
    assign rd_fire         = s_axi_arready_o & s_axi_arvalid_i;
    assign wr_ofs          = {s_axi_awaddr_i[AW-1:2], 2'b00};
    assign rd_ofs          = {s_axi_araddr_i[AW-1:2], 2'b00};

    assign s_axi_bvalid_o  = bvalid_reg;
    assign s_axi_bresp_o   = bresp_reg;
    assign s_axi_rvalid_o  = rvalid_reg;
    assign s_axi_rdata_o   = rdata_reg;
    assign s_axi_rresp_o   = rresp_reg;

    // byte-lane merge of a 16-bit register
    function [15:0] merge16;
        input [15:0] old;
        input [15:0] wd;
        input [1:0]  strb;
        begin
            merge16 = {strb[1] ? wd[15:8] : old[15:8],
                       strb[0] ? wd[7:0] : old[7:0]};
        end
    endfunction

    wire amc_hit;
    wire rvc_hit;
    wire wr_known;

    assign amc_hit  = (wr_ofs == `BRWAG_OFS_AMC);
    assign rvc_hit  = (wr_ofs == `BRWAG_OFS_RVC);
    // status registers are read-only; writes to them answer OKAY and are dropped
    assign wr_known = amc_hit | rvc_hit | (wr_ofs == `BRWAG_OFS_STAT) | (wr_ofs == `BRWAG_OFS_LAST);

    always @(posedge clk_i) begin
        if (!resetn_i) begin
            addr_mode_control_reg <= `BRWAG_AMC_RESET;
            reversal_control_reg  <= `BRWAG_RVC_RESET;
            bvalid_reg            <= 1'b0;
            bresp_reg             <= `BRWAG_RESP_OKAY;
        end else if (ce_i) begin
            if (wr_fire) begin
                if (amc_hit) begin
                    // reserved bits stay zero
                    addr_mode_control_reg <= merge16(addr_mode_control_reg, s_axi_wdata_i[15:0], s_axi_wstrb_i[1:0])
                                             & `BRWAG_AMC_WMASK;
                end
                if (rvc_hit) begin
                    reversal_control_reg <= merge16(reversal_control_reg, s_axi_wdata_i[15:0], s_axi_wstrb_i[1:0]);
                end
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_known ? `BRWAG_RESP_OKAY : `BRWAG_RESP_SLVERR;
            end else if (s_axi_bready_i) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    reg [31:0] rd_mux;
    reg        rd_known;

    always @* begin
        rd_mux   = 32'h0000_0000;
        rd_known = 1'b1;
        case (rd_ofs)
            `BRWAG_OFS_AMC: begin
                rd_mux[15:0] = addr_mode_control_reg;
            end
            `BRWAG_OFS_RVC: begin
                rd_mux[15:0] = reversal_control_reg;
            end
            `BRWAG_OFS_STAT: begin
                rd_mux = {circ_count_reg, rev_count_reg};
            end
            `BRWAG_OFS_LAST: begin
                rd_mux = {13'h0000, rev_applied_reg, circ_check_reg, ptr_update_reg, ptr_next_reg};
            end
            default: begin
                rd_known = 1'b0;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (!resetn_i) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= `BRWAG_RESP_OKAY;
        end else if (ce_i) begin
            if (rd_fire) begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= rd_mux;
                rresp_reg  <= rd_known ? `BRWAG_RESP_OKAY : `BRWAG_RESP_SLVERR;
            end else if (s_axi_rready_i) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // ---------------- address generation ----------------
    reg           is_inc;
    reg           is_dec;
    reg           is_pre;
    reg           is_offset;
    wire          ptr_changes;
    wire          rev_ptr_hit;
    wire          rev_active;
    wire          x_circ_hit;
    wire          y_circ_hit;
    wire          circ_active;
    wire [PW-1:0] step;
    wire [PW-1:0] plain_next;
    wire [14:0]   rev_sum;
    wire [PW-1:0] rev_next;
    wire [PW-1:0] new_ptr;
    wire [PW-1:0] new_ea;

    // mode decode; plain indirect and the spare code 7 leave every flag low,
    // so an unknown mode behaves as a plain indirect access
    always @* begin
        is_inc    = 1'b0;
        is_dec    = 1'b0;
        is_pre    = 1'b0;
        is_offset = 1'b0;
        case (req_mode_i)
            `BRWAG_MODE_POST_INC: begin
                is_inc = 1'b1;
            end
            `BRWAG_MODE_PRE_INC: begin
                is_inc = 1'b1;
                is_pre = 1'b1;
            end
            `BRWAG_MODE_POST_DEC: begin
                is_dec = 1'b1;
            end
            `BRWAG_MODE_PRE_DEC: begin
                is_dec = 1'b1;
                is_pre = 1'b1;
            end
            `BRWAG_MODE_REG_IDX,
            `BRWAG_MODE_LIT_OFS: begin
                // offset modes never write the pointer back
                is_offset = 1'b1;
            end
            default: begin
                is_offset = 1'b0;
            end
        endcase
    end

    assign ptr_changes = is_inc | is_dec;
    assign step        = req_byte_i ? `BRWAG_STEP_BYTE : `BRWAG_STEP_WORD;

    assign rev_ptr_hit = (reversal_pointer_select != `BRWAG_SEL_NONE)
                         & (req_ptr_sel_i == reversal_pointer_select);
    assign rev_active  = reversal_enable & rev_ptr_hit
                         & req_write_i & ~req_yside_i
                         & is_inc
                         & ~req_byte_i;

    assign x_circ_hit  = x_circular_enable & ~req_yside_i
                         & (x_circular_pointer_select != `BRWAG_SEL_NONE)
                         & (req_ptr_sel_i == x_circular_pointer_select);
    assign y_circ_hit  = y_circular_enable & req_yside_i
                         & (y_circular_pointer_select != `BRWAG_SEL_NONE)
                         & ((y_circular_pointer_select == `BRWAG_YSEL_W10)
                            | (y_circular_pointer_select == `BRWAG_YSEL_W11))
                         & (req_ptr_sel_i == y_circular_pointer_select);
    // reversal wins on writes, circular wins on reads
    assign circ_active = (x_circ_hit | y_circ_hit) & ~rev_active;

    assign plain_next  = is_dec ? req_ptr_i - step : req_ptr_i + step;

    // modifier lands one bit up so the sum works on word addresses
    brwag_rev_adder #(
        .W (15)
    ) u_rev_adder (
        .a_i   (req_ptr_i[15:1]),
        .b_i   (reversal_modifier),
        .sum_o (rev_sum)
    );

    // invalid modifiers still sum, just into a useless sequence
    assign rev_next    = {rev_sum, req_ptr_i[0]};
    assign new_ptr     = rev_active ? rev_next : plain_next;
    assign new_ea      = is_offset ? req_ptr_i + req_offset_i
                       : (is_pre ? new_ptr : req_ptr_i);

    // counters wrap silently; software should read them as deltas
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            ea_valid_reg    <= 1'b0;
            ea_reg          <= {PW{1'b0}};
            ptr_next_reg    <= {PW{1'b0}};
            ptr_update_reg  <= 1'b0;
            rev_applied_reg <= 1'b0;
            circ_check_reg  <= 1'b0;
            rev_count_reg   <= 16'h0000;
            circ_count_reg  <= 16'h0000;
        end else if (ce_i) begin
            ea_valid_reg <= req_valid_i;
            if (req_valid_i) begin
                ea_reg          <= new_ea;
                // offset modes leave the pointer as it was
                ptr_next_reg    <= ptr_changes ? new_ptr : req_ptr_i;
                ptr_update_reg  <= ptr_changes;
                rev_applied_reg <= rev_active;
                circ_check_reg  <= circ_active;
                if (rev_active) begin
                    rev_count_reg <= rev_count_reg + 16'h0001;
                end
                if (circ_active) begin
                    circ_count_reg <= circ_count_reg + 16'h0001;
                end
            end
        end
    end

    assign ea_valid_o         = ea_valid_reg;
    assign ea_o               = ea_reg;
    assign ptr_next_o         = ptr_next_reg;
    assign ptr_update_o       = ptr_update_reg;
    assign reversal_applied_o = rev_applied_reg;
    assign circular_check_o   = circ_check_reg;

    // prot inputs carry no meaning here
    wire unused_prot;
    assign unused_prot = ^{s_axi_awprot_i, s_axi_arprot_i, s_axi_wdata_i[31:16], s_axi_wstrb_i[3:2]};
endmodule

// ### hw/brwag_consts.vh
`ifndef BRWAG_CONSTS_VH
`define BRWAG_CONSTS_VH

// register byte offsets
`define BRWAG_OFS_AMC        4'h0
`define BRWAG_OFS_RVC        4'h4
`define BRWAG_OFS_STAT       4'h8
`define BRWAG_OFS_LAST       4'hc

// addressing mode control fields
`define BRWAG_AMC_XCIR_EN    15
`define BRWAG_AMC_YCIR_EN    14
`define BRWAG_AMC_RSV_HI     13
`define BRWAG_AMC_RSV_LO     12
`define BRWAG_AMC_RSEL_HI    11
`define BRWAG_AMC_RSEL_LO    8
`define BRWAG_AMC_YSEL_HI    7
`define BRWAG_AMC_YSEL_LO    4
`define BRWAG_AMC_XSEL_HI    3
`define BRWAG_AMC_XSEL_LO    0
`define BRWAG_AMC_WMASK      16'hcfff
`define BRWAG_AMC_RESET      16'h0000

// reversal control fields
`define BRWAG_RVC_EN         15
`define BRWAG_RVC_MOD_HI     14
`define BRWAG_RVC_MOD_LO     0
`define BRWAG_RVC_RESET      16'h0000

// pointer select code meaning none, and the Y circular select codes for W10 and W11
`define BRWAG_SEL_NONE       4'hf
`define BRWAG_YSEL_W10       4'ha
`define BRWAG_YSEL_W11       4'hb

// addressing modes from the pipeline
`define BRWAG_MODE_IND       3'h0
`define BRWAG_MODE_POST_INC  3'h1
`define BRWAG_MODE_POST_DEC  3'h2
`define BRWAG_MODE_PRE_INC   3'h3
`define BRWAG_MODE_PRE_DEC   3'h4
`define BRWAG_MODE_REG_IDX   3'h5
`define BRWAG_MODE_LIT_OFS   3'h6

// pointer steps in bytes
`define BRWAG_STEP_WORD      16'h0002
`define BRWAG_STEP_BYTE      16'h0001

// bus responses
`define BRWAG_RESP_OKAY      2'b00
`define BRWAG_RESP_SLVERR    2'b10

`endif

// ### hw/brwag_rev_adder.v
`timescale 1ns/10ps
// reverse-carry sum: carries run from msb toward lsb
module brwag_rev_adder #(
    parameter W = 15
) (
    input  wire [W-1:0] a_i,
    input  wire [W-1:0] b_i,
    output wire [W-1:0] sum_o
);
    wire [W:0] carry;

    assign carry[W] = 1'b0;

    genvar k;
    generate
        for (k = W - 1; k >= 0; k = k - 1) begin : g_bit
            assign sum_o[k]   = a_i[k] ^ b_i[k] ^ carry[k+1];
            // carry out of bit 0 drops off the end
            assign carry[k]   = (a_i[k] & b_i[k]) | (carry[k+1] & (a_i[k] ^ b_i[k]));
        end
    endgenerate
endmodule

// ### dv/brwag_props.sv
`timescale 1ns/10ps
module brwag_props #(
    parameter AW = 4,
    parameter PW = 16
) (
    input wire          clk_i,
    input wire          resetn_i,
    input wire          req_valid_i,
    input wire          req_write_i,
    input wire          req_yside_i,
    input wire          req_byte_i,
    input wire [2:0]    req_mode_i,
    input wire [PW-1:0] req_ptr_i,
    input wire          s_axi_awvalid_i,
    input wire          s_axi_awready_o,
    input wire          s_axi_bvalid_o,
    input wire          ea_valid_o,
    input wire [PW-1:0] ptr_next_o,
    input wire          ptr_update_o,
    input wire          reversal_applied_o,
    input wire          circular_check_o
);
    wire rev_w = ea_valid_o && reversal_applied_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    ea_latency_a: assert property (req_valid_i |=> ea_valid_o) else $error("no result after request");
    ea_pulse_a: assert property (!req_valid_i |=> !ea_valid_o && $stable(ptr_next_o)) else $error("result moved");
    rev_source_a:
        assert property (rev_w |-> $past(req_write_i) && !$past(req_yside_i)) else $error("reversal on read");
    rev_word_a: assert property (rev_w |-> !$past(req_byte_i)) else $error("reversal on byte");
    rev_mode_a:
        assert property (rev_w |-> $past(req_mode_i) inside {3'h1, 3'h3}) else $error("reversal in wrong mode");
    rev_bit0_a:
        assert property (rev_w |-> ((ptr_next_o ^ $past(req_ptr_i)) & 16'h0001) == 16'h0000) else $error("bit 0 moved");
    rev_precede_a: assert property (rev_w |-> !circular_check_o) else $error("circular on write");
    update_flag_a:
        assert property (ea_valid_o |-> ptr_update_o == ($past(req_mode_i) inside {[3'h1:3'h4]}))
            else $error("update flag wrong");
    ptr_hold_a:
        assert property (ea_valid_o && !ptr_update_o |-> ptr_next_o == $past(req_ptr_i)) else $error("pointer moved");
    wr_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o |=> s_axi_bvalid_o) else $error("no write answer");
    cover property (rev_w);
    cover property (ea_valid_o && circular_check_o);
    cover property (s_axi_bvalid_o ##1 !s_axi_bvalid_o);
endmodule

// ### dv/brwag_pipe_model.sv
`timescale 1ns/10ps
module brwag_pipe_model #(
    parameter PW = 16
) (
    input  wire           clk_i,
    input  wire           ea_valid_i,
    input  wire           ptr_update_i,
    input  wire [PW-1:0]  ptr_next_i,
    output logic          req_valid_o,
    output logic          req_write_o,
    output logic          req_yside_o,
    output logic          req_byte_o,
    output logic [2:0]    req_mode_o,
    output logic [3:0]    req_ptr_sel_o,
    output logic [PW-1:0] req_ptr_o,
    output logic [PW-1:0] req_offset_o
);
    logic [PW-1:0] wreg [16];
    initial begin
        {req_valid_o, req_write_o, req_yside_o, req_byte_o, req_mode_o, req_ptr_sel_o} = '0;
        req_ptr_o = '0;
        req_offset_o = '0;
    end
    // select stays put after release, so the writeback finds its register
    always @(posedge clk_i) begin
        if (ea_valid_i && ptr_update_i) begin
            wreg[req_ptr_sel_o] <= ptr_next_i;
        end
    end
    task issue(input logic w, y, b, input logic [2:0] m, input logic [3:0] s, input logic [PW-1:0] o);
        req_valid_o <= 1'b1;
        {req_write_o, req_yside_o, req_byte_o, req_mode_o, req_ptr_sel_o} <= {w, y, b, m, s};
        req_ptr_o <= wreg[s];
        req_offset_o <= o;
        @(posedge clk_i);
        req_valid_o <= 1'b0;
        // released data lines flip so a late sample cannot match
        req_ptr_o <= ~req_ptr_o;
        req_offset_o <= ~req_offset_o;
    endtask
endmodule

// ### dv/bit_reversed_write_address_gen_tb.sv
`timescale 1ns/10ps
module bit_reversed_write_address_gen_tb;
    logic        clk_i, resetn_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
    logic [4:0]  s_axi_awaddr_i, s_axi_araddr_i;
    logic [31:0] s_axi_wdata_i;
    logic [3:0]  s_axi_wstrb_i;
    wire         ce_i = 1'b1;
    wire [2:0]   s_axi_awprot_i = 3'h0;
    wire [2:0]   s_axi_arprot_i = 3'h0;
    wire         s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    wire [1:0]   s_axi_bresp_o, s_axi_rresp_o;
    wire [31:0]  s_axi_rdata_o;
    wire         req_valid_i, req_write_i, req_yside_i, req_byte_i;
    wire [2:0]   req_mode_i;
    wire [3:0]   req_ptr_sel_i;
    wire [15:0]  req_ptr_i, req_offset_i, ea_o, ptr_next_o;
    wire         ea_valid_o, ptr_update_o, reversal_applied_o, circular_check_o;
    logic [15:0] amc, rvc;
    logic [63:0] eq[$], rq[$], bq[$];
    int          fails, n_compared;
    logic [15:0] cfg_a[6] = '{16'h81f1, 16'hc2a2, 16'h4bb0, 16'h0fb1, 16'h8e1e, 16'hffff};
    logic [15:0] cfg_r[6] = '{16'h8008, 16'hc000, 16'h8002, 16'h8001, 16'h0004, 16'h8010};

    brwag_top #(.AW(5), .PW(16)) brwag_top_inst (.*);
    brwag_pipe_model #(.PW(16)) brwag_pipe_model_inst (.clk_i(clk_i), .ea_valid_i(ea_valid_o),
        .ptr_update_i(ptr_update_o), .ptr_next_i(ptr_next_o), .req_valid_o(req_valid_i), .req_write_o(req_write_i),
        .req_yside_o(req_yside_i), .req_byte_o(req_byte_i), .req_mode_o(req_mode_i), .req_ptr_sel_o(req_ptr_sel_i),
        .req_ptr_o(req_ptr_i), .req_offset_o(req_offset_i));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task cmp(input string nm, input logic [63:0] e, input logic [63:0] s);
        n_compared++;
        if (e !== s) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask

    always @(posedge clk_i) begin
        if (ea_valid_o === 1'b1) cmp("result", eq.pop_front(), {ea_o, ptr_next_o, ptr_update_o, reversal_applied_o,
            circular_check_o});
        if (s_axi_rvalid_o === 1'b1 && s_axi_rready_i) cmp("rdata", rq.pop_front(), {s_axi_rresp_o, s_axi_rdata_o});
        if (s_axi_bvalid_o === 1'b1 && s_axi_bready_i) cmp("bresp", bq.pop_front(), {62'h0, s_axi_bresp_o});
    end

    function logic [15:0] rcadd(input logic [15:0] p, input logic [14:0] m);
        logic [14:0] a, c, s;
        for (int i = 0; i < 15; i++) {a[i], c[i]} = {p[15-i], m[14-i]};
        s = a + c;
        for (int i = 0; i < 15; i++) p[15-i] = s[i];
        return p;
    endfunction

    function logic [34:0] expect_req(input logic w, y, b, input logic [2:0] m, input logic [3:0] s,
                                     input logic [15:0] p, o);
        logic rv, cm;
        logic [15:0] st, pn, ea;
        rv = rvc[15] && amc[11:8] != 4'hf && s == amc[11:8] && w && !y && !b && m inside {3'h1, 3'h3};
        cm = y ? amc[14] && amc[7:4] inside {4'ha, 4'hb} && s == amc[7:4]
               : amc[15] && amc[3:0] != 4'hf && s == amc[3:0];
        st = b ? 16'h0001 : 16'h0002;
        pn = m inside {3'h1, 3'h3} ? (rv ? rcadd(p, rvc[14:0]) : p + st) : m inside {3'h2, 3'h4} ? p - st : p;
        ea = m inside {3'h3, 3'h4} ? pn : m >= 3'h5 ? p + o : p;
        return {ea, pn, m inside {[3'h1:3'h4]}, rv, cm && !rv};
    endfunction

    task axi_wr(input logic [4:0] a, input logic [15:0] d, input logic [1:0] r);
        int n;
        bq.push_back({62'h0, r});
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= {16'h0, d};
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'b111;
        @(posedge clk_i);
        for (n = 0; n < 100 && s_axi_awready_o !== 1'b1; n++) @(posedge clk_i);
        {s_axi_awvalid_i, s_axi_wvalid_i} <= 2'b00;
        while (n < 100 && s_axi_bvalid_o !== 1'b1) begin
            @(posedge clk_i);
            n++;
        end
        s_axi_bready_i <= 1'b0;
        if (n >= 100) fails++;
    endtask

    task axi_rd(input logic [4:0] a, input logic [15:0] d, input logic [1:0] r);
        int n;
        rq.push_back({r, 16'h0, d});
        s_axi_araddr_i <= a;
        {s_axi_arvalid_i, s_axi_rready_i} <= 2'b11;
        @(posedge clk_i);
        for (n = 0; n < 100 && s_axi_arready_o !== 1'b1; n++) @(posedge clk_i);
        s_axi_arvalid_i <= 1'b0;
        while (n < 100 && s_axi_rvalid_o !== 1'b1) begin
            @(posedge clk_i);
            n++;
        end
        s_axi_rready_i <= 1'b0;
        if (n >= 100) fails++;
    endtask

    task run_reqs(input int cnt);
        logic w, y, b;
        logic [2:0] m;
        logic [3:0] s;
        logic [3:0] pick[4];
        logic [15:0] o;
        repeat (cnt) begin
            pick = '{amc[11:8], amc[3:0], amc[7:4], 4'($urandom)};
            s = pick[$urandom_range(3)];
            {w, b, o} = 18'($urandom);
            y = !w && 1'($urandom);
            m = 3'($urandom_range(6));
            eq.push_back(expect_req(w, y, b, m, s, brwag_pipe_model_inst.wreg[s], o));
            brwag_pipe_model_inst.issue(w, y, b, m, s, o);
            // writeback lands one edge after the result, so wait two to four edges
            repeat (2 + $urandom_range(2)) @(posedge clk_i);
        end
    endtask

    initial begin
        {resetn_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
        {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
        s_axi_wstrb_i = 4'h3;
        {fails, n_compared} = '0;
        void'($urandom(59));
        for (int i = 0; i < 16; i++) brwag_pipe_model_inst.wreg[i] = 16'($urandom);
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        axi_rd(5'h00, 16'h0000, 2'b00);
        axi_rd(5'h04, 16'h0000, 2'b00);
        axi_wr(5'h10, 16'h1234, 2'b10);
        axi_rd(5'h10, 16'h0000, 2'b10);
        $display("reset and map checks done");
        for (int i = 0; i < 6; i++) begin
            amc = cfg_a[i] & 16'hcfff;
            rvc = cfg_r[i];
            axi_wr(5'h04, rvc, 2'b00);
            axi_wr(5'h00, cfg_a[i], 2'b00);
            axi_rd(5'h00, amc, 2'b00);
            axi_rd(5'h04, rvc, 2'b00);
            // no pointer read straight after a control write
            repeat (2) @(posedge clk_i);
            run_reqs(30);
            $display("config %0d done", i);
        end
        repeat (3) @(posedge clk_i);
        tally_and_finish;
    end

    initial begin
        repeat (6000) @(posedge clk_i);
        fails++;
        tally_and_finish;
    end
endmodule

bind brwag_top brwag_props #(.AW(AW), .PW(PW)) brwag_props_inst (.*);
